// [rtl/psc_device.sv]
// Synthesizer configuration bank: serial receiver, words, power and lock pin
// Function
// - two address bits pick one of four words
// - host holds pin low or requests powerdown first
// - words undefined until host writes each address
// - power-on: pin low, write 0,1,2, release
// - frequency change via init word then feedback
// - frequency change via counter clear and powerdown
// - frequency change via pin low around feedback
// - host writes zeros in reference bits 17:14
// - precision bit picks lock counts 15/3 or 31/7
// - reference divide 1..16383, never zero
// - host keeps compare rate at most 55 MHz
// - feedback bit 18 selects high pump current
// - programmable count bits 17:5, not 0..2
// - swallow count bits 4:0, any value
// - host keeps programmable count >= 3, >= swallow
// - function word field layout, others zero
// - pin and request bits pick power state
// - sync powerdown waits for compare signal edge
// - async powerdown on committing load strobe edge
// - boost lasts 3 plus 4 times duration cycles
// - lock pin selector output table
// - init word loads counters, tristates pump
// - counter clear holds both dividers reset
`timescale 1ns/1ns
module psc_device
  import psc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  psc_link_if.dev link,
  input wire logic phase_compare_frequency, // Compare-rate signal, async
  input wire logic lock_digital, // Digital lock flag from lock logic
  input wire logic lock_analog_low, // Raw phase result, low pulls pin
  input wire logic fb_div_out, // Feedback divider output
  input wire logic ref_div_out, // Reference divider output
  output logic [13:0] ref_divide, // Reference divide number
  output logic [12:0] prog_count, // Programmable count
  output logic [4:0] swallow_count, // Swallow count
  output logic [5:0] lock_in_count, // Cycles to declare lock
  output logic [5:0] lock_out_count, // Cycles to declare loss
  output logic pump_high, // High pump current active
  output logic pump_tristate, // Pump output off
  output logic pump_polarity, // Pump polarity
  output logic counters_hold, // Dividers held in reset or load state
  output logic powered_down, // All circuits off
  output psc_pwr_type power_state, // Decoded power state
  output logic lock_pin_o, // Lock pin level
  output logic lock_pin_oe, // Lock pin drive enable
  output logic switch_pin_low // Loop filter switch driven low
);
`include "psc_defs.svh"
  // Two-flop synchronisers for every link pin and the compare signal
  // All five inputs come from other domains: the host's pins, the compare rate
  // The third stage only keeps history for the edge detectors below
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r; // Edge history, fed only from the second stage
  wire [4:0] pins_in = {phase_compare_frequency, link.powerdown_pin_low,
    link.load_strobe, link.serial_data, link.serial_clk};
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Edge detectors; reset values match the idle pin levels,
  // so no false edge follows reset
  wire sclk_rise = s2_r[0] & ~s3_r[0];
  wire le_rise = s2_r[2] & ~s3_r[2];
  wire pin_high = s2_r[3];
  wire pfd_flip = s2_r[4] ^ s3_r[4];
  // Shift register: last 21 bits clocked in, MSB first
  // Bits enter on each synchronised serial clock rise
  // A longer frame keeps only its last 21 bits
  // Cleared on reset so a stray strobe commits zeros
  logic [`PSC_FRAME_W-1:0] shift_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 21'h00_0000;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[`PSC_FRAME_W-2:0], s2_r[1]};
    end
  end
  wire [1:0] frame_addr = shift_r[1:0];
  wire [18:0] frame_word = shift_r[`PSC_FRAME_W-1:2];
  // Word in the upper 19 bits, address in the low two
  // Address decode, only on the strobe's rising edge
  wire wr_ref = le_rise && (frame_addr == `PSC_ADDR_REF);
  wire wr_fb = le_rise && (frame_addr == `PSC_ADDR_FB);
  wire wr_fn = le_rise && (frame_addr == `PSC_ADDR_FUNC);
  wire wr_init = le_rise && (frame_addr == `PSC_ADDR_INIT);
  // Configuration words; reset to zero though the part itself is undefined
  logic [18:0] ref_r;
  logic [18:0] fb_r;
  logic [18:0] fn_r;
  // Init word shares the function layout and also loads it
  // The load state ends with the next feedback word
  logic init_hold_r; // Load state after the init word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_r <= 19'h0_0000;
      fb_r <= 19'h0_0000;
      fn_r <= 19'h0_0000;
      init_hold_r <= 1'b0;
    end else begin
      if (wr_ref) ref_r <= frame_word;
      if (wr_fb) fb_r <= frame_word;
      if (wr_fn || wr_init) fn_r <= frame_word & `PSC_FN_MASK;
      if (wr_init) init_hold_r <= 1'b1;
      else if (wr_fb) init_hold_r <= 1'b0;
    end
  end
  // Field extraction
  // Unused function bits were already masked off on write
  wire [3:0] tmr_fld = fn_r[`PSC_FN_TMR_HI:`PSC_FN_TMR_LO];
  wire [2:0] ld_sel = fn_r[`PSC_FN_LD_HI:`PSC_FN_LD_LO];
  wire boost_feature_enable = fn_r[`PSC_FN_BOOST_EN];
  wire timed_boost_select = fn_r[`PSC_FN_TIMED];
  wire powerdown_request = fn_r[`PSC_FN_PD_REQ];
  wire sync_powerdown_select = fn_r[`PSC_FN_SYNC_PD];
  // Counts feed the divider datapath outside this block
  // Lock counts come in fixed pairs, chosen by one bit
  // Zero is kept as stored; the host must never write it
  assign ref_divide = ref_r[`PSC_REF_DIV_HI:0];
  assign prog_count = fb_r[`PSC_FB_B_HI:`PSC_FB_B_LO];
  assign swallow_count = fb_r[`PSC_FB_A_HI:0];
  assign lock_in_count = ref_r[`PSC_REF_PREC_BIT] ? `PSC_LOCK_IN_HI
    : `PSC_LOCK_IN_LO;
  assign lock_out_count = ref_r[`PSC_REF_PREC_BIT] ? `PSC_LOCK_OUT_HI
    : `PSC_LOCK_OUT_LO;
  // Power state decode
  // Pin low wins over any register setting
  wire [1:0] req_state = !powerdown_request ? 2'b00
    : (sync_powerdown_select ? 2'b11 : 2'b10);
  assign power_state = !pin_high ? PSC_PWR_PIN : psc_pwr_type'(req_state);
  // Power-down flop: async mode acts on the committing strobe edge itself
  // Sync mode waits for any level change of the compare signal
  // Trade-off: that change is seen two cycles late, after the synchroniser
  // Reset starts powered down, like a part with its pin held low
  logic pd_r;
  wire pd_async_now = wr_fn && frame_word[`PSC_FN_PD_REQ]
    && !frame_word[`PSC_FN_SYNC_PD];
  wire pd_sync_now = (power_state == PSC_PWR_SYNC) && pfd_flip;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pd_r <= 1'b1;
    end else if (!pin_high) begin
      pd_r <= 1'b1;
    end else if (pd_async_now || pd_sync_now || power_state == PSC_PWR_ASYNC) begin
      pd_r <= 1'b1;
    end else if (power_state == PSC_PWR_NORMAL) begin
      pd_r <= 1'b0;
    end
  end
  assign powered_down = pd_r || !pin_high;
  // Fast-lock boost timer in compare cycles: 3 + 4 * duration
  // Only rising compare edges count as cycles
  // A new feedback word restarts the timer; expiry clears the gain bit
  // Without timed mode the boost stays until software clears it
  logic [5:0] boost_cnt_r;
  logic boost_r; // Pump gain bit, cleared by timer expiry
  wire [5:0] boost_len = {tmr_fld, 2'b11};
  wire cmp_tick = pfd_flip && s2_r[4];
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      boost_cnt_r <= 6'h00;
      boost_r <= 1'b0;
    end else if (wr_fb || wr_init) begin
      boost_r <= wr_fb & frame_word[`PSC_FB_BOOST_BIT];
      boost_cnt_r <= 6'h00;
    end else if (boost_r && boost_feature_enable && timed_boost_select
        && cmp_tick) begin
      if (boost_cnt_r == boost_len - 6'h01) begin
        boost_r <= 1'b0;
      end else begin
        boost_cnt_r <= boost_cnt_r + 6'h01;
      end
    end
  end
  assign pump_high = boost_r;
  // Switch pin follows the gain bit while boost is enabled,
  // otherwise it shows the timed select bit, inverted
  assign switch_pin_low = boost_feature_enable ? boost_r : !timed_boost_select;
  assign pump_tristate = fn_r[`PSC_FN_TRI] || init_hold_r;
  assign pump_polarity = fn_r[`PSC_FN_POL];
  // Counters stay held while the init load state lasts
  assign counters_hold = fn_r[`PSC_FN_CLR] || init_hold_r;
  // Lock pin selector; analog mode is open drain
  // Open drain: released while the raw phase result is high
  // Codes 110 and 111 fall to the default low level
  always_comb begin
    lock_pin_o = 1'b0;
    lock_pin_oe = 1'b1;
    case (ld_sel)
      3'b001: lock_pin_o = lock_digital;
      3'b010: lock_pin_o = fb_div_out;
      3'b011: lock_pin_o = 1'b1;
      3'b100: lock_pin_o = ref_div_out;
      3'b101: lock_pin_oe = !lock_analog_low;
      default: lock_pin_o = 1'b0;
    endcase
  end
endmodule : psc_device

// [rtl/psc_defs.svh]
// Constants for the synthesizer configuration bank: offsets, fields, timing
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_ADDR_REF 2'h0
`define PSC_ADDR_FB 2'h1
`define PSC_ADDR_FUNC 2'h2
`define PSC_ADDR_INIT 2'h3
`define PSC_WORD_W 19
`define PSC_FRAME_W 21
`define PSC_REF_PREC_BIT 18
`define PSC_REF_DIV_HI 13
`define PSC_FB_BOOST_BIT 18
`define PSC_FB_B_HI 17
`define PSC_FB_B_LO 5
`define PSC_FB_A_HI 4
`define PSC_FN_SYNC_PD 17
`define PSC_FN_TMR_HI 13
`define PSC_FN_TMR_LO 10
`define PSC_FN_TIMED 9
`define PSC_FN_BOOST_EN 7
`define PSC_FN_TRI 6
`define PSC_FN_POL 5
`define PSC_FN_LD_HI 4
`define PSC_FN_LD_LO 2
`define PSC_FN_PD_REQ 1
`define PSC_FN_CLR 0
`define PSC_FN_MASK 19'h2_3EFF
`define PSC_LOCK_IN_LO 6'd15
`define PSC_LOCK_OUT_LO 6'd3
`define PSC_LOCK_IN_HI 6'd31
`define PSC_LOCK_OUT_HI 6'd7
`define PSC_SCLK_DIV 8'h04
`define PSC_REG_CMD 2'h0
`define PSC_REG_DATA 2'h1
`define PSC_REG_STAT 2'h2
`endif

// [rtl/psc_pkg.sv]
// Types shared by both ends of the synthesizer serial link
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_PWR_NORMAL = 2'b00,
    PSC_PWR_PIN = 2'b01,
    PSC_PWR_ASYNC = 2'b10,
    PSC_PWR_SYNC = 2'b11
  } psc_pwr_type;
  typedef enum logic [3:0] {
    PSC_H_IDLE = 4'b0001,
    PSC_H_SHIFT = 4'b0010,
    PSC_H_LOAD = 4'b0100,
    PSC_H_DONE = 4'b1000
  } psc_hstate_type;
endpackage : psc_pkg

// [rtl/psc_link_if.sv]
// Three-wire serial link plus power-down pin between host and synthesizer
`timescale 1ns/1ns
interface psc_link_if;
  logic serial_clk; // Shift clock, made by the host
  logic serial_data; // Data, MSB first
  logic load_strobe; // Rising edge commits a frame
  logic powerdown_pin_low; // Low forces power down
  modport host (output serial_clk, output serial_data, output load_strobe,
    output powerdown_pin_low);
  modport dev (input serial_clk, input serial_data, input load_strobe,
    input powerdown_pin_low);
endinterface : psc_link_if

// [rtl/psc_host.sv]
// Host controller: shifts 21-bit frames out and drives the power-down pin
`timescale 1ns/1ns
module psc_host
  import psc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  psc_link_if.host link
);
`include "psc_defs.svh"
  // Command port: data, then command (bit0 go, bit1 pin level)
  logic [18:0] data_r;
  logic [1:0] waddr_r;
  logic pin_r; // Starts low so the device stays powered down
  logic [31:0] rdata_r;
  psc_hstate_type st_r;
  psc_hstate_type st_nxt;
  logic [20:0] sh_r;
  logic [4:0] bit_r;
  logic [7:0] div_r;
  logic sclk_r;
  wire go = wr_en && (addr == `PSC_REG_CMD) && wdata[0] && (st_r == PSC_H_IDLE);
  wire div_end = (div_r == `PSC_SCLK_DIV);
  // Register writes; the host checks no value ranges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_r <= 19'h0_0000;
      waddr_r <= 2'h0;
      pin_r <= 1'b0;
    end else if (wr_en && addr == `PSC_REG_DATA) begin
      data_r <= wdata[18:0];
      waddr_r <= wdata[25:24];
    end else if (wr_en && addr == `PSC_REG_CMD) begin
      pin_r <= wdata[1];
    end
  end
  // Read data one cycle later; status shows busy and pin
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      if (addr == `PSC_REG_STAT) rdata_r <= {30'h0000_0000, pin_r, st_r != PSC_H_IDLE};
      else if (addr == `PSC_REG_DATA) rdata_r <= {6'h00, waddr_r, 5'h00, data_r};
      else rdata_r <= 32'h0000_0000;
    end
  end
  assign rdata = rdata_r;
  // Sequencer: shift 21 bits at clk_sys/(2*(div+1)), then pulse strobe
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PSC_H_IDLE: if (go) st_nxt = PSC_H_SHIFT;
      PSC_H_SHIFT: if (div_end && sclk_r && bit_r == 5'd20) st_nxt = PSC_H_LOAD;
      PSC_H_LOAD: if (div_end) st_nxt = PSC_H_DONE;
      PSC_H_DONE: if (div_end) st_nxt = PSC_H_IDLE;
      default: st_nxt = PSC_H_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= PSC_H_IDLE;
      sh_r <= 21'h00_0000;
      bit_r <= 5'h00;
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= (go || div_end) ? 8'h00 : div_r + 8'h01;
      if (go) begin
        sh_r <= {data_r, waddr_r};
        bit_r <= 5'h00;
        sclk_r <= 1'b0;
      end else if (st_r == PSC_H_SHIFT && div_end) begin
        sclk_r <= !sclk_r;
        if (sclk_r) begin
          sh_r <= {sh_r[19:0], 1'b0};
          bit_r <= bit_r + 5'h01;
        end
      end
    end
  end
  assign link.serial_clk = sclk_r;
  assign link.serial_data = sh_r[20];
  assign link.load_strobe = (st_r == PSC_H_LOAD);
  assign link.powerdown_pin_low = pin_r;
endmodule : psc_host

// [dv/psc_link_props.sv]
// Checker for the serial link and the decoded power and lock outputs
`timescale 1ns/1ns
module psc_link_props
  import psc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic powerdown_pin_low,
  input wire logic powered_down,
  input wire psc_pwr_type power_state,
  input wire logic [5:0] lock_in_count,
  input wire logic [5:0] lock_out_count
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Cycles since the strobe was last high; words may only change near it
  logic [3:0] since_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) since_r <= 4'hF;
    else if (load_strobe) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  end
  strobe_width_a: assert property ($rose(load_strobe) |-> load_strobe [*5] ##1 !load_strobe)
    else $error("load strobe pulse width wrong");
  sclk_half_a: assert property ($rose(serial_clk) |-> serial_clk [*5] ##1 !serial_clk)
    else $error("serial clock half period wrong");
  data_hold_a: assert property (serial_clk |-> $stable(serial_data))
    else $error("serial data moved while clock high");
  sclk_still_a: assert property (load_strobe |-> !serial_clk)
    else $error("serial clock high during strobe");
  word_commit_a: assert property ($changed(lock_in_count) |-> since_r <= 4'h3)
    else $error("word changed away from strobe");
  pin_forces_a: assert property ($fell(powerdown_pin_low) |-> ##[1:4] power_state == PSC_PWR_PIN)
    else $error("pin low did not force power down");
  normal_up_a: assert property (power_state == PSC_PWR_NORMAL |-> ##[0:1] !powered_down)
    else $error("powered down in normal state");
  forced_down_a: assert property (power_state inside {PSC_PWR_PIN, PSC_PWR_ASYNC} |-> ##[0:1] powered_down)
    else $error("not powered down in forced state");
  lock_pair_a: assert property (lock_in_count == 6'hF ? lock_out_count == 6'h3 : (lock_in_count == 6'h1F && lock_out_count == 6'h7))
    else $error("lock counts not a legal pair");
endmodule : psc_link_props

// [dv/tb_top.sv]
// Testbench: host and device joined over the serial link
`timescale 1ns/1ns
module tb_top
  import psc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pcf = 1'b0; // Compare-rate signal, held still until the sync test
  logic alow = 1'b0; // Raw phase result, low pulls the lock pin
  logic [31:0] rdata;
  logic [13:0] ref_divide;
  logic [12:0] prog_count;
  logic [4:0] swallow_count;
  logic [5:0] lock_in_count, lock_out_count;
  logic pump_high, pump_tristate, pump_polarity, counters_hold, powered_down;
  logic lock_pin_o, lock_pin_oe, switch_pin_low;
  psc_pwr_type power_state;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  psc_link_if link ();
  psc_host psc_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .link(link));
  // Digital lock high, feedback low, reference high: codes 001, 011 and 100 read high, the rest low
  psc_device psc_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
    .phase_compare_frequency(pcf), .lock_digital(1'b1), .lock_analog_low(alow),
    .fb_div_out(1'b0), .ref_div_out(1'b1), .ref_divide(ref_divide), .prog_count(prog_count),
    .swallow_count(swallow_count), .lock_in_count(lock_in_count),
    .lock_out_count(lock_out_count), .pump_high(pump_high), .pump_tristate(pump_tristate),
    .pump_polarity(pump_polarity), .counters_hold(counters_hold),
    .powered_down(powered_down), .power_state(power_state), .lock_pin_o(lock_pin_o),
    .lock_pin_oe(lock_pin_oe), .switch_pin_low(switch_pin_low));
  psc_link_props psc_link_props_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data),
    .load_strobe(link.load_strobe), .powerdown_pin_low(link.powerdown_pin_low),
    .powered_down(powered_down), .power_state(power_state),
    .lock_in_count(lock_in_count), .lock_out_count(lock_out_count));
  always #10 clk_sys = ~clk_sys;
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // Cut a hang short; a full run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : bus_wr
  // Read data stand from the cycle after the strobe until the next read
  task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask : bus_rd
  // One whole frame: load the data register, start it with the pin level, poll busy
  task automatic send(input logic [1:0] a, input logic [18:0] w, input logic p);
    logic [31:0] s = 32'h1;
    int n = 0;
    bus_wr(2'h1, {6'h0, a, 5'h0, w});
    bus_wr(2'h0, {30'h0, p, 1'b1});
    while (s[0] !== 1'b0 && n < 200) begin
      bus_rd(2'h2, s);
      n++;
    end
    if (n == 200) error_cnt++;
    repeat (6) @(posedge clk_sys);
  endtask : send
  task automatic pin(input logic p);
    bus_wr(2'h0, {30'h0, p, 1'b0});
    repeat (6) @(posedge clk_sys);
  endtask : pin
  task automatic t_reset();
    logic [31:0] s;
    chk(PSC_PWR_PIN, power_state);
    bus_rd(2'h3, s);
    chk(32'h0, s);
    $display("test reset done");
  endtask : t_reset
  task automatic t_power_on();
    send(2'h0, 19'h4_3FFF, 1'b0);
    send(2'h1, 19'h0_0063, 1'b0);
    send(2'h2, 19'h0_002C, 1'b0);
    chk(PSC_PWR_PIN, power_state);
    pin(1'b1);
    chk(PSC_PWR_NORMAL, power_state);
    chk(14'h3FFF, ref_divide);
    chk(6'h1F, lock_in_count);
    chk(6'h7, lock_out_count);
    chk(13'h3, prog_count);
    chk(5'h3, swallow_count);
    chk(1'b1, pump_polarity);
    chk(1'b1, lock_pin_o);
    $display("test power on done");
  endtask : t_power_on
  task automatic t_fields();
    send(2'h0, 19'h0_0001, 1'b1);
    chk(14'h1, ref_divide);
    chk(6'hF, lock_in_count);
    chk(6'h3, lock_out_count);
    send(2'h1, 19'h7_FFFF, 1'b1);
    chk(13'h1FFF, prog_count);
    chk(5'h1F, swallow_count);
    chk(1'b1, pump_high);
    send(2'h1, 19'h0_0063, 1'b1);
    chk(1'b0, pump_high);
    $display("test fields done");
  endtask : t_fields
  task automatic t_lock();
    logic [7:0] tab = 8'h1A;
    for (int c = 0; c < 8; c++) begin
      send(2'h2, {14'h0, c[2:0], 2'b00}, 1'b1);
      if (c == 5) chk(2'b10, {lock_pin_oe, lock_pin_o});
      else chk(tab[c], lock_pin_o);
    end
    send(2'h2, 19'h0_0014, 1'b1);
    @(posedge clk_sys);
    alow <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(1'b0, lock_pin_oe);
    $display("test lock pin done");
  endtask : t_lock
  task automatic t_power();
    send(2'h2, 19'h0_0003, 1'b1);
    chk(PSC_PWR_ASYNC, power_state);
    chk(1'b1, powered_down);
    chk(1'b1, counters_hold);
    send(2'h1, 19'h0_0063, 1'b1);
    send(2'h2, 19'h0_0000, 1'b1);
    chk(PSC_PWR_NORMAL, power_state);
    chk(1'b0, counters_hold);
    send(2'h2, 19'h2_0002, 1'b1);
    chk(PSC_PWR_SYNC, power_state);
    chk(1'b0, powered_down);
    @(posedge clk_sys);
    pcf <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(1'b1, powered_down);
    send(2'h2, 19'h0_0000, 1'b1);
    pin(1'b0);
    chk(PSC_PWR_PIN, power_state);
    send(2'h1, 19'h0_0063, 1'b0);
    pin(1'b1);
    chk(PSC_PWR_NORMAL, power_state);
    $display("test power modes done");
  endtask : t_power
  // Timed boost of 7 compare cycles, with the pump tristated meanwhile
  task automatic t_boost();
    send(2'h2, 19'h0_06C0, 1'b1);
    chk(1'b1, pump_tristate);
    send(2'h1, 19'h4_0063, 1'b1);
    chk(1'b1, switch_pin_low);
    for (int k = 0; k < 7; k++) begin
      pcf <= 1'b0;
      repeat (4) @(posedge clk_sys);
      pcf <= 1'b1;
      repeat (4) @(posedge clk_sys);
      if (k == 5) chk(1'b1, pump_high);
    end
    chk(1'b0, pump_high);
    chk(1'b0, switch_pin_low);
    $display("test boost timer done");
  endtask : t_boost
  task automatic t_init();
    send(2'h3, 19'h0_0000, 1'b1);
    chk(1'b1, counters_hold);
    chk(1'b1, pump_tristate);
    send(2'h1, 19'h0_0063, 1'b1);
    chk(1'b0, counters_hold);
    chk(1'b0, pump_tristate);
    $display("test init word done");
  endtask : t_init
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_power_on();
    t_fields();
    t_lock();
    t_power();
    t_boost();
    t_init();
    stop_test();
  end
endmodule : tb_top
